// File: hdl/ubc_usb_config.sv
// USB boot configuration and command handling controller.
`timescale 1ns/100ps
`include "ubc_consts.svh"
module ubc_usb_config #(
  parameter int RESP_CYCLES = `UBC_RESP_MS * `UBC_CLK_KHZ
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cmdValid,
  input ubc_pkg::ubc_cmd_t cmdIn,
  output logic respValid,
  output ubc_pkg::ubc_resp_t respOut,
  input wire logic bootDone,
  output logic usbStart,
  output ubc_pkg::ubc_cfg_t cfgOut,
  output logic [7:0] vendorStrByte,
  output logic [7:0] productStrByte,
  input wire logic [4:0] strIndex,
  output logic [15:0] inVolume,
  output logic [15:0] outVolume,
  output logic [2:0] endpointsEnabled,
  input wire logic [3:0] gpiEvent,
  output logic hidNotify,
  output logic [3:0] hidBits,
  output logic timeout
);
  localparam int STR_LEN = `UBC_STR_LEN;

  // ---------------------------------------------------------------
  // Command intake
  // ---------------------------------------------------------------
  logic bufValid;
  logic take;
  logic overrun;
  ubc_pkg::ubc_cmd_t cur;

  ubc_cmd_buffer u_buf (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .inValid(cmdValid),
    .inCmd(cmdIn),
    .take(take),
    .outValid(bufValid),
    .outCmd(cur),
    .overrun(overrun)
  );

  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_RESP} ubc_state_t;
  ubc_state_t state_r;

  assign take = (state_r == S_IDLE) && bufValid;

  ubc_pkg::ubc_cmd_t work_r;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      work_r <= '0;
    end else if (take) begin
      work_r <= cur;
    end
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic isUsbOp;
  logic bootOk;
  logic known;
  logic writeOk;
  always_comb begin
    isUsbOp = (work_r.op >= `UBC_OP_VENDOR_ID) && (work_r.op <= `UBC_OP_START);
    known = isUsbOp || (work_r.op == `UBC_OP_VOLUME);
    bootOk = work_r.fromBoot && !usbStart;
    writeOk = known && !work_r.isRead && (!isUsbOp || bootOk);
  end

  // ---------------------------------------------------------------
  // Configuration store
  // ---------------------------------------------------------------
  logic doWrite;
  assign doWrite = (state_r == S_EXEC) && writeOk;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfgOut.vendorId <= `UBC_DEF_VENDOR;
      cfgOut.productId <= `UBC_DEF_PRODUCT;
      cfgOut.bcdDevice <= `UBC_DEF_BCD;
      cfgOut.serialMode <= '0;
      cfgOut.inRate <= `UBC_DEF_RATE;
      cfgOut.outRate <= `UBC_DEF_RATE;
      cfgOut.inDepth <= `UBC_DEF_DEPTH;
      cfgOut.outDepth <= `UBC_DEF_DEPTH;
    end else if (doWrite) begin
      unique case (work_r.op)
        `UBC_OP_VENDOR_ID: cfgOut.vendorId <= work_r.data;
        `UBC_OP_PRODUCT_ID: cfgOut.productId <= work_r.data;
        `UBC_OP_BCD_DEVICE: cfgOut.bcdDevice <= work_r.data;
        `UBC_OP_SERIAL: cfgOut.serialMode <= work_r.data;
        `UBC_OP_IN_RATE: cfgOut.inRate <= work_r.data;
        `UBC_OP_OUT_RATE: cfgOut.outRate <= work_r.data;
        `UBC_OP_IN_DEPTH: cfgOut.inDepth <= work_r.data;
        `UBC_OP_OUT_DEPTH: cfgOut.outDepth <= work_r.data;
        default: ;
      endcase
    end
  end

  logic [7:0] vendorStr_r [STR_LEN];
  logic [7:0] productStr_r [STR_LEN];
  logic idxOk;
  assign idxOk = int'(work_r.index) < STR_LEN;

  genvar gi;
  generate
    for (gi = 0; gi < STR_LEN; gi++) begin : g_str
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          vendorStr_r[gi] <= '0;
          productStr_r[gi] <= '0;
        end else if (doWrite && (int'(work_r.index) == gi)) begin
          if (work_r.op == `UBC_OP_VENDOR_STR) vendorStr_r[gi] <= work_r.data[7:0];
          if (work_r.op == `UBC_OP_PRODUCT_STR) productStr_r[gi] <= work_r.data[7:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      vendorStrByte <= '0;
      productStrByte <= '0;
    end else begin
      vendorStrByte <= (int'(strIndex) < STR_LEN) ? vendorStr_r[strIndex] : 8'h00;
      productStrByte <= (int'(strIndex) < STR_LEN) ? productStr_r[strIndex] : 8'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      inVolume <= `UBC_VOL_FULL;
      outVolume <= `UBC_VOL_FULL;
    end else if (doWrite && work_r.op == `UBC_OP_VOLUME) begin
      if (work_r.index[0]) outVolume <= work_r.data[15:0];
      else inVolume <= work_r.data[15:0];
    end
  end

  // ---------------------------------------------------------------
  // Start flag and endpoints
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      usbStart <= 1'b0;
    end else if (doWrite && work_r.op == `UBC_OP_START && work_r.data[0]) begin
      usbStart <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      endpointsEnabled <= '0;
    end else begin
      endpointsEnabled <= {3{usbStart}};
    end
  end

  // ---------------------------------------------------------------
  // Execution and answer
  // ---------------------------------------------------------------
  logic [31:0] rdData;
  logic strOp;
  always_comb begin
    strOp = (work_r.op == `UBC_OP_VENDOR_STR) || (work_r.op == `UBC_OP_PRODUCT_STR);
    unique case (work_r.op)
      `UBC_OP_VENDOR_ID: rdData = cfgOut.vendorId;
      `UBC_OP_PRODUCT_ID: rdData = cfgOut.productId;
      `UBC_OP_BCD_DEVICE: rdData = cfgOut.bcdDevice;
      `UBC_OP_IN_RATE: rdData = cfgOut.inRate;
      `UBC_OP_OUT_RATE: rdData = cfgOut.outRate;
      `UBC_OP_IN_DEPTH: rdData = cfgOut.inDepth;
      `UBC_OP_OUT_DEPTH: rdData = cfgOut.outDepth;
      `UBC_OP_START: rdData = {31'h0000_0000, usbStart};
      `UBC_OP_VENDOR_STR: rdData = idxOk ? {24'h00_0000, vendorStr_r[work_r.index]} : 32'h0000_0000;
      `UBC_OP_PRODUCT_STR: rdData = idxOk ? {24'h00_0000, productStr_r[work_r.index]} : 32'h0000_0000;
      `UBC_OP_VOLUME: rdData = {16'h0000, work_r.index[0] ? outVolume : inVolume};
      default: rdData = 32'h0000_0000;
    endcase
  end

  logic cmdGood;
  assign cmdGood = work_r.isRead ? (known && work_r.op != `UBC_OP_SERIAL && (!strOp || idxOk))
                                 : (writeOk && (!strOp || idxOk));

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= S_IDLE;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          if (bufValid) state_r <= S_EXEC;
        end
        S_EXEC: state_r <= S_RESP;
        S_RESP: state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      respValid <= 1'b0;
      respOut <= '0;
    end else begin
      respValid <= state_r == S_EXEC;
      if (state_r == S_EXEC) begin
        respOut.status <= cmdGood ? `UBC_ST_OK : `UBC_ST_ERR;
        respOut.data <= (cmdGood && work_r.isRead) ? rdData : 32'h0000_0000;
      end
    end
  end

  // Counts busy cycles; a stuck command shows as a timeout level.
  logic [31:0] busy_r;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busy_r <= '0;
      timeout <= 1'b0;
    end else begin
      busy_r <= (state_r == S_IDLE) ? 32'h0000_0000 : busy_r + 32'h0000_0001;
      timeout <= busy_r >= 32'(RESP_CYCLES);
    end
  end

  // ---------------------------------------------------------------
  // HID input events
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hidNotify <= 1'b0;
      hidBits <= '0;
    end else begin
      hidNotify <= usbStart && (gpiEvent != 4'h0);
      hidBits <= usbStart ? gpiEvent : 4'h0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_take;
    state_r == S_IDLE && bufValid;
  endsequence
  sequence s_answer;
    ##2 respValid;
  endsequence

  a_answer_time: assert property (@(posedge sys_clk) disable iff (sys_rst) s_take |-> s_answer)
    else $error("answer not two cycles after take");
  a_late_setting: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_r == S_EXEC && isUsbOp && usbStart && !work_r.isRead) |=> respOut.status == `UBC_ST_ERR)
    else $error("boot-only setting accepted after start");
  a_runtime_block: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_r == S_EXEC && work_r.op == `UBC_OP_VENDOR_ID && !work_r.fromBoot) |=> $stable(cfgOut.vendorId))
    else $error("runtime identity write took effect");
  a_start_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst) $rose(usbStart) |=> usbStart)
    else $error("start flag dropped");
  a_start_cause: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(usbStart) |-> $past(doWrite) && $past(work_r.op) == `UBC_OP_START)
    else $error("start without start command");
  a_error_nodata: assert property (@(posedge sys_clk) disable iff (sys_rst)
    respValid && respOut.status == `UBC_ST_ERR |-> respOut.data == 32'h0000_0000)
    else $error("error answer carried data");
  a_ep_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
    usbStart |=> endpointsEnabled == 3'h7)
    else $error("endpoints not enabled after start");
  a_hid_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    hidNotify |-> $past(usbStart) && $past(gpiEvent) != 4'h0)
    else $error("hid notify without event");
  a_single_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst) respValid |=> !respValid)
    else $error("answer longer than one cycle");

  // ---------------------------------------------------------------
  // Reset, lock-out and event checks
  // ---------------------------------------------------------------
  sequence s_late_usb_write;
    state_r == S_EXEC && isUsbOp && !work_r.isRead && !bootOk;
  endsequence
  sequence s_error_answer;
    respValid && respOut.status == `UBC_ST_ERR;
  endsequence

  a_no_overrun: assert property (@(posedge sys_clk) disable iff (sys_rst) !overrun)
    else $error("command arrived while another was pending");
  a_no_timeout: assert property (@(posedge sys_clk) disable iff (sys_rst) !timeout)
    else $error("command took too long");
  a_usb_locked: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_late_usb_write |=> $stable(cfgOut) && $stable(usbStart))
    else $error("locked USB setting changed");
  a_late_error: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_late_usb_write |=> s_error_answer)
    else $error("locked USB setting not refused");
  a_unknown_error: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_r == S_EXEC && !known) |=> s_error_answer)
    else $error("unknown command not refused");
  a_str_range: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_r == S_EXEC && strOp && !idxOk) |=> s_error_answer)
    else $error("string index out of range not refused");
  a_serial_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_r == S_EXEC && work_r.isRead && work_r.op == `UBC_OP_SERIAL) |=> s_error_answer)
    else $error("write-only serial setting was read");
  a_read_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_r == S_EXEC && work_r.isRead) |=> $stable(cfgOut) && $stable(usbStart))
    else $error("read changed a setting");
  a_volume_open: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_r == S_EXEC && work_r.op == `UBC_OP_VOLUME && !work_r.isRead) |=> respOut.status == `UBC_ST_OK)
    else $error("volume setting refused at run time");
  a_start_boot: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(usbStart) |-> $past(work_r.fromBoot))
    else $error("start flag set outside the boot list");
  a_start_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) usbStart |=> usbStart)
    else $error("start flag cleared without reset");
  a_ep_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !usbStart |=> endpointsEnabled == 3'h0)
    else $error("endpoints enabled before start");
  a_reset_ident: assert property (@(posedge sys_clk)
    sys_rst |=> cfgOut.vendorId == `UBC_DEF_VENDOR && cfgOut.productId == `UBC_DEF_PRODUCT)
    else $error("identifiers not at default after reset");
  a_reset_rates: assert property (@(posedge sys_clk)
    sys_rst |=> cfgOut.inRate == `UBC_DEF_RATE && cfgOut.outRate == `UBC_DEF_RATE)
    else $error("sample rates not at default after reset");
  a_reset_depths: assert property (@(posedge sys_clk)
    sys_rst |=> cfgOut.inDepth == `UBC_DEF_DEPTH && cfgOut.outDepth == `UBC_DEF_DEPTH)
    else $error("bit depths not at default after reset");
  a_reset_volume: assert property (@(posedge sys_clk)
    sys_rst |=> inVolume == `UBC_VOL_FULL && outVolume == `UBC_VOL_FULL)
    else $error("volumes not at full scale after reset");
  a_reset_start: assert property (@(posedge sys_clk)
    sys_rst |=> !usbStart && endpointsEnabled == 3'h0)
    else $error("USB started during reset");
  a_hid_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !usbStart |=> !hidNotify && hidBits == 4'h0)
    else $error("input event reported before start");
  a_hid_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (usbStart && gpiEvent != 4'h0) |=> hidNotify && hidBits == $past(gpiEvent))
    else $error("input event not reported");
endmodule

// File: hdl/ubc_consts.svh
// Constants for the USB boot configuration controller.
// Summary of operation
// - Most commands answered within 30 ms.
// - Failed command returns error; reads return value.
// - Commands always accepted and buffered; unknown or locked ones answered with error.
// - Boot list executed at startup over defaults.
// - Boot list takes run-time and boot-only commands.
// - Audio, control and HID endpoints presented.
// - Volume controls start at full scale.
// - Default vendor and product identifiers used.
// - USB setup only from boot list, before enumeration.
// - USB setting commands honoured only from boot.
// - Start flag write of 1 begins USB.
// - Both sample rates default to 48000.
// - Both bit depths default to 16.
// - Strings 25 bytes; identifiers 32-bit values.
// - Serial setting selects serial index behaviour.
// - HID endpoint reports general-purpose input events.
`ifndef UBC_CONSTS_SVH
`define UBC_CONSTS_SVH
`define UBC_OP_VENDOR_ID 8'h01
`define UBC_OP_PRODUCT_ID 8'h02
`define UBC_OP_BCD_DEVICE 8'h03
`define UBC_OP_VENDOR_STR 8'h04
`define UBC_OP_PRODUCT_STR 8'h05
`define UBC_OP_SERIAL 8'h06
`define UBC_OP_IN_RATE 8'h07
`define UBC_OP_OUT_RATE 8'h08
`define UBC_OP_IN_DEPTH 8'h09
`define UBC_OP_OUT_DEPTH 8'h0A
`define UBC_OP_START 8'h0B
`define UBC_OP_VOLUME 8'h10
`define UBC_DEF_VENDOR 32'h0000_1234
`define UBC_DEF_PRODUCT 32'h0000_5678
`define UBC_DEF_BCD 32'h0000_0100
`define UBC_DEF_RATE 32'h0000_BB80
`define UBC_DEF_DEPTH 32'h0000_0010
`define UBC_VOL_FULL 16'h0000
`define UBC_STR_LEN 25
`define UBC_RESP_MS 30
`define UBC_CLK_KHZ 100000
`define UBC_ST_OK 2'h0
`define UBC_ST_ERR 2'h1
`define UBC_ST_BUSY 2'h2
`endif

// File: hdl/ubc_pkg.sv
// Types shared by the USB boot configuration controller.
package ubc_pkg;
  typedef struct packed {
    logic [7:0] op;
    logic isRead;
    logic fromBoot;
    logic [4:0] index;
    logic [31:0] data;
  } ubc_cmd_t;
  typedef struct packed {
    logic [1:0] status;
    logic [31:0] data;
  } ubc_resp_t;
  typedef struct packed {
    logic [31:0] vendorId;
    logic [31:0] productId;
    logic [31:0] bcdDevice;
    logic [31:0] serialMode;
    logic [31:0] inRate;
    logic [31:0] outRate;
    logic [31:0] inDepth;
    logic [31:0] outDepth;
  } ubc_cfg_t;
endpackage

// File: hdl/ubc_cmd_buffer.sv
// One-command holding buffer that always accepts a command.
`timescale 1ns/100ps
module ubc_cmd_buffer (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic inValid,
  input ubc_pkg::ubc_cmd_t inCmd,
  input wire logic take,
  output logic outValid,
  output ubc_pkg::ubc_cmd_t outCmd,
  output logic overrun
);
  // A new command overwrites a held one; the host is expected to wait.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      outValid <= 1'b0;
      outCmd <= '0;
      overrun <= 1'b0;
    end else begin
      overrun <= inValid && outValid && !take;
      if (inValid) begin
        outValid <= 1'b1;
        outCmd <= inCmd;
      end else if (take) begin
        outValid <= 1'b0;
      end
    end
  end
endmodule

// File: tb/ubc_host_model.sv
// Host-side model that sends control commands and waits for each answer.
`timescale 1ns/100ps
module ubc_host_model (
  input wire logic sys_clk,
  output logic cmdValid,
  output ubc_pkg::ubc_cmd_t cmdIn,
  input wire logic respValid,
  input ubc_pkg::ubc_resp_t respOut
);
  initial begin
    cmdValid = 1'b0;
    cmdIn = '1;
  end

  // Presents one command for one edge, then waits up to 1000 edges for the answer to be sampled.
  // The command lines show the inverse afterwards so stale values never look valid.
  task automatic issue(input ubc_pkg::ubc_cmd_t c, output ubc_pkg::ubc_resp_t r, output int lat);
    lat = 0;
    cmdValid <= 1'b1;
    cmdIn <= c;
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    cmdIn <= ~c;
    while (respValid !== 1'b1 && lat < 1000) begin
      @(posedge sys_clk);
      lat++;
    end
    r = respOut;
  endtask
endmodule

// File: tb/tb.sv
// Self-checking testbench for the USB boot configuration controller.
`timescale 1ns/100ps
`include "ubc_consts.svh"
module tb;
  typedef struct packed {
    ubc_pkg::ubc_cmd_t c;
    logic [1:0] st;
    logic [31:0] rd;
  } ubc_row_t;
  logic sys_clk, sys_rst, bootDone, cmdValid, respValid, usbStart, hidNotify, timeout;
  ubc_pkg::ubc_cmd_t cmdIn;
  ubc_pkg::ubc_resp_t respOut, r;
  ubc_pkg::ubc_cfg_t cfgOut;
  logic [7:0] vendorStrByte, productStrByte;
  logic [4:0] strIndex;
  logic [15:0] inVolume, outVolume;
  logic [2:0] endpointsEnabled;
  logic [3:0] gpiEvent, hidBits;
  int err_total, comparisons, lat;
  ubc_row_t rows[21];

  ubc_usb_config #(.RESP_CYCLES(50)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmdValid(cmdValid),
    .cmdIn(cmdIn), .respValid(respValid), .respOut(respOut), .bootDone(bootDone), .usbStart(usbStart),
    .cfgOut(cfgOut), .vendorStrByte(vendorStrByte), .productStrByte(productStrByte), .strIndex(strIndex),
    .inVolume(inVolume), .outVolume(outVolume), .endpointsEnabled(endpointsEnabled), .gpiEvent(gpiEvent),
    .hidNotify(hidNotify), .hidBits(hidBits), .timeout(timeout));
  ubc_host_model host (.sys_clk(sys_clk), .cmdValid(cmdValid), .cmdIn(cmdIn), .respValid(respValid),
    .respOut(respOut));

  // ----------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (2000) @(posedge sys_clk);
    err_total++;
    stop_test();
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The answer is sampled at the second edge after the edge that takes the command.
  task automatic send(input ubc_pkg::ubc_cmd_t c, input logic [1:0] st);
    host.issue(c, r, lat);
    check(32'(r.status), 32'(st));
    check(32'(lat), 32'h0000_0003);
    check(32'(timeout), 32'h0);
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check_defaults();
    check(cfgOut.vendorId, `UBC_DEF_VENDOR);
    check(cfgOut.productId, `UBC_DEF_PRODUCT);
    check(cfgOut.inRate, 32'h0000_BB80);
    check(cfgOut.outRate, 32'h0000_BB80);
    check(cfgOut.inDepth, 32'h0000_0010);
    check(cfgOut.outDepth, 32'h0000_0010);
    check({inVolume, outVolume}, 32'h0000_0000);
    check(32'(usbStart), 32'h0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    bootDone = 1'b0;
    strIndex = 5'h00;
    gpiEvent = 4'h0;
    // Opcodes: 01 vendor, 02 product, 03 release, 04/05 strings, 06 serial, 07-0A rates and depths, 0B start,
    // 10 volume.
    rows = '{
      '{'{8'h01, 1'b0, 1'b1, 5'h00, 32'h0000_ABCD}, 2'h0, 32'h0},
      '{'{8'h01, 1'b1, 1'b1, 5'h00, 32'h0}, 2'h0, 32'h0000_ABCD},
      '{'{8'h02, 1'b0, 1'b1, 5'h00, 32'h0000_0042}, 2'h0, 32'h0},
      '{'{8'h02, 1'b1, 1'b0, 5'h00, 32'h0}, 2'h0, 32'h0000_0042},
      '{'{8'h03, 1'b0, 1'b1, 5'h00, 32'h0000_0200}, 2'h0, 32'h0},
      '{'{8'h06, 1'b0, 1'b1, 5'h00, 32'h0000_0001}, 2'h0, 32'h0},
      '{'{8'h06, 1'b1, 1'b1, 5'h00, 32'h0}, 2'h1, 32'h0},
      '{'{8'h07, 1'b0, 1'b1, 5'h00, 32'h0000_3E80}, 2'h0, 32'h0},
      '{'{8'h08, 1'b0, 1'b1, 5'h00, 32'h0000_7D00}, 2'h0, 32'h0},
      '{'{8'h09, 1'b0, 1'b1, 5'h00, 32'h0000_0018}, 2'h0, 32'h0},
      '{'{8'h0A, 1'b0, 1'b1, 5'h00, 32'h0000_0020}, 2'h0, 32'h0},
      '{'{8'h04, 1'b0, 1'b1, 5'h03, 32'h0000_0041}, 2'h0, 32'h0},
      '{'{8'h04, 1'b0, 1'b1, 5'h19, 32'h0000_0042}, 2'h1, 32'h0},
      '{'{8'h05, 1'b0, 1'b1, 5'h18, 32'h0000_005A}, 2'h0, 32'h0},
      '{'{8'h01, 1'b0, 1'b0, 5'h00, 32'h0000_9999}, 2'h1, 32'h0},
      '{'{8'hFF, 1'b0, 1'b1, 5'h00, 32'h0}, 2'h1, 32'h0},
      '{'{8'h0B, 1'b0, 1'b1, 5'h00, 32'h0000_0001}, 2'h0, 32'h0},
      '{'{8'h01, 1'b0, 1'b1, 5'h00, 32'h0000_7777}, 2'h1, 32'h0},
      '{'{8'h07, 1'b1, 1'b0, 5'h00, 32'h0}, 2'h0, 32'h0000_3E80},
      '{'{8'h10, 1'b0, 1'b0, 5'h01, 32'h0000_0123}, 2'h0, 32'h0},
      '{'{8'h10, 1'b1, 1'b0, 5'h01, 32'h0}, 2'h0, 32'h0000_0123}
    };
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    gpiEvent <= 4'hA;
    @(posedge sys_clk);
    check_defaults();
    check(32'(endpointsEnabled), 32'h0);
    foreach (rows[i]) begin
      send(rows[i].c, rows[i].st);
      if (rows[i].c.isRead) check(r.data, rows[i].rd);
      if (i == 15) check(32'({hidNotify, hidBits}), 32'h0);
    end
    check(cfgOut.vendorId, 32'h0000_ABCD);
    check(cfgOut.serialMode, 32'h0000_0001);
    check({cfgOut.bcdDevice[15:0], cfgOut.outRate[15:0]}, 32'h0200_7D00);
    check({cfgOut.inDepth[15:0], cfgOut.outDepth[15:0]}, 32'h0018_0020);
    check(32'(usbStart), 32'h1);
    check(32'(endpointsEnabled), 32'h7);
    check({inVolume, outVolume}, 32'h0000_0123);
    gpiEvent <= 4'h5;
    strIndex <= 5'h03;
    repeat (2) @(posedge sys_clk);
    check(32'(hidBits), 32'h5);
    check(32'(hidNotify), 32'h1);
    check(32'(vendorStrByte), 32'h41);
    strIndex <= 5'h18;
    repeat (2) @(posedge sys_clk);
    check({vendorStrByte, productStrByte}, 32'h005A);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    check_defaults();
    send('{8'h0B, 1'b0, 1'b0, 5'h00, 32'h0000_0001}, 2'h1);
    send('{8'h0B, 1'b0, 1'b1, 5'h00, 32'h0000_0000}, 2'h0);
    check(32'(usbStart), 32'h0);
    stop_test();
  end
endmodule
